// ### include/cfhr_params.svh
`ifndef CFHR_PARAMS_SVH
`define CFHR_PARAMS_SVH
// ==========================================
// Register offsets (byte addresses)
`define CFHR_OFS_PC 8'h00
`define CFHR_OFS_SP 8'h04
`define CFHR_OFS_REFRESH 8'h08
`define CFHR_OFS_CTRL 8'h0C
`define CFHR_OFS_STATUS 8'h10
// ==========================================
// Field positions
`define CFHR_CTRL_IEL_BIT 0
`define CFHR_CTRL_IM_LSB 1
`define CFHR_STAT_HALT_BIT 0
`define CFHR_STAT_IRQ_BIT 1
// ==========================================
// Reset values and fixed addresses
`define CFHR_PC_RESET 16'h0000
`define CFHR_REFRESH_RESET 8'h00
`define CFHR_PAGE_RESET 8'h00
`define CFHR_IM_RESET 2'h0
`define CFHR_NMI_VECTOR 16'h0066
// ==========================================
// Timing counts in clock cycles
`define CFHR_DUMMY_CYCLES 2
`define CFHR_NOP_CYCLES 4
`endif

// ### include/cfhr_pkg.sv
package cfhr_pkg;
  // ==========================================
  // Commands from the instruction decoder
  typedef enum logic [3:0] {
    CFHR_OP_FETCH, CFHR_OP_JUMP, CFHR_OP_CALL, CFHR_OP_RET, CFHR_OP_PUSH, CFHR_OP_POP,
    CFHR_OP_HALT, CFHR_OP_EI, CFHR_OP_DI, CFHR_OP_EXX, CFHR_OP_IM, CFHR_OP_LDSP
  } cfhr_op_e;
  // Sequencer states
  typedef enum logic [2:0] {
    CFHR_ST_DUMMY, CFHR_ST_IDLE, CFHR_ST_HALTED, CFHR_ST_PUSH_LO,
    CFHR_ST_POP_A, CFHR_ST_POP_B, CFHR_ST_POP_C
  } cfhr_state_e;
  // One decoded command: pair 0 BC, 1 DE, 2 HL, 3 AF
  typedef struct packed {
    cfhr_op_e op;
    logic [1:0] pair;
    logic [15:0] arg;
  } cfhr_cmd_s;
  // Memory bus request, strobes active low
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cfhr_mem_s;
endpackage

// ### rtl/cfhr_pair_file.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register pairs with an alternate bank
module cfhr_pair_file
  import cfhr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [1:0] rd_sel_i,
  output logic [15:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [15:0] wr_data_i,
  input wire logic swap_alternate_set_i
);
  // No reset: pairs keep their contents across reset
  logic [15:0] main_bank [4];
  logic [15:0] alt_bank [4];

  assign rd_data_o = main_bank[rd_sel_i];

  // Pop writes a pair; the exchange swaps BC, DE and HL but not AF
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (swap_alternate_set_i && i != 3) begin
        main_bank[i] <= alt_bank[i];
        alt_bank[i] <= main_bank[i];
      end else if (wr_en_i && wr_sel_i == 2'(i)) begin
        main_bank[i] <= wr_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/cfhr_flow_ctrl.sv
// Functional notes
// - 16-bit stack pointer, down on push, up on pop
// - Calls and interrupts stack PC; returns restore it
// - No other register saved automatically
// - Push/pop move named pair, last-in first-out
// - Stack pointer not initialised by reset
// - Call stores high at SP-1, low at SP-2
// - 16-bit PC increments when driven for fetch
// - Jumps, calls, interrupts, returns load PC instead
// - Halt drives halt status low
// - Halted: NOP fetches, PC held, refresh continues
// - Registers kept throughout halt
// - Accepted interrupt ends halt; maskable needs latch
// - Reset ends halt and clears PC
// - Two dummy cycles, then fetch from zero
// - Reset clears enable latch, selects mode zero
// - Reset drives control outputs inactive high
// - Reset clears page and refresh registers
// - Refresh low seven bits count every fetch
//
// Chosen here: the register addresses and strobed register access.
`include "cfhr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfhr_flow_ctrl
  import cfhr_pkg::*;
#(
  parameter int DUMMY_CYCLES = `CFHR_DUMMY_CYCLES,
  parameter int NOP_CYCLES = `CFHR_NOP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Decoder command port
  input wire logic cmd_valid_i,
  input wire cfhr_cmd_s cmd_i,
  output logic cmd_ready_o,
  // Interrupt requests
  input wire logic nmi_req_i,
  input wire logic int_req_i,
  input wire logic [15:0] int_vector_i,
  // System memory bus
  output cfhr_mem_s mem_o,
  input wire logic [7:0] mem_rdata_i,
  output logic halt_n_o,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  // ==========================================
  // State
  cfhr_state_e state, next_state;
  logic [15:0] program_counter; // Next instruction address
  logic [15:0] stack_pointer; // Top of stack, no reset value
  logic [7:0] refresh; // Refresh counter
  logic [7:0] page; // Interrupt page register
  logic interrupt_enable_latch; // Maskable interrupt enable
  logic next_iel;
  logic [1:0] int_mode; // Maskable interrupt mode
  logic nmi_pend, next_nmi_pend; // Latched NMI request
  logic irq_arm; // Interrupt to be accepted next cycle
  logic [1:0] dcnt; // Dummy cycle counter
  logic [$clog2(NOP_CYCLES+1)-1:0] nop_cnt; // NOP spacing divider
  logic nop_tick; // One-cycle enable for a halted NOP
  logic [15:0] push_word; // Word being pushed
  logic [15:0] jump_tgt; // PC target after a push
  logic load_tgt; // Push ends with a PC load
  logic pop_to_pc; // Pop ends in the PC
  logic [1:0] pop_pair; // Pair selected for a pop
  logic [7:0] pop_low; // Low byte of a pop
  logic [15:0] pair_rdata;
  logic take, go, go_nmi, refresh_tick;

  // Address arithmetic shared by the stack paths
  function automatic logic [15:0] addr_add(input logic [15:0] a, input logic [15:0] d);
    addr_add = a + d;
  endfunction

  // ==========================================
  // Next-state decisions
  always_comb begin
    next_state = state;
    take = cmd_valid_i && cmd_ready_o;
    // Interrupts are only taken at an instruction boundary or in halt
    go = irq_arm && (state == CFHR_ST_IDLE || state == CFHR_ST_HALTED);
    go_nmi = go && nmi_pend;
    unique case (state)
      CFHR_ST_DUMMY: begin
        if (dcnt == 2'(DUMMY_CYCLES - 1)) next_state = CFHR_ST_IDLE;
      end
      CFHR_ST_IDLE: begin
        if (go) begin
          next_state = CFHR_ST_PUSH_LO;
        end else if (take) begin
          unique case (cmd_i.op)
            CFHR_OP_CALL, CFHR_OP_PUSH: next_state = CFHR_ST_PUSH_LO;
            CFHR_OP_RET, CFHR_OP_POP: next_state = CFHR_ST_POP_A;
            CFHR_OP_HALT: next_state = CFHR_ST_HALTED;
            default: next_state = CFHR_ST_IDLE;
          endcase
        end
      end
      CFHR_ST_HALTED: begin
        if (go) next_state = CFHR_ST_PUSH_LO;
      end
      CFHR_ST_PUSH_LO: next_state = CFHR_ST_IDLE;
      CFHR_ST_POP_A: next_state = CFHR_ST_POP_B;
      CFHR_ST_POP_B: next_state = CFHR_ST_POP_C;
      CFHR_ST_POP_C: next_state = CFHR_ST_IDLE;
    endcase
  end

  // Enable latch and pending NMI; a register write overrides the latch, the NMI set wins over the clear
  always_comb begin
    next_iel = interrupt_enable_latch;
    if (take && cmd_i.op == CFHR_OP_EI) next_iel = 1'b1;
    if (take && cmd_i.op == CFHR_OP_DI) next_iel = 1'b0;
    if (go) next_iel = 1'b0;
    if (reg_wr_i && reg_addr_i == `CFHR_OFS_CTRL) next_iel = reg_wdata_i[`CFHR_CTRL_IEL_BIT];
    next_nmi_pend = (nmi_pend && !go_nmi) || nmi_req_i;
  end

  assign refresh_tick = (take && cmd_i.op == CFHR_OP_FETCH) || (nop_tick && !go);

  // ==========================================
  // Sequencer state and dummy count
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= CFHR_ST_DUMMY;
      dcnt <= 2'h0;
    end else begin
      state <= next_state;
      dcnt <= (state == CFHR_ST_DUMMY) ? dcnt + 2'h1 : 2'h0;
    end
  end

  // Interrupt arming is decided one cycle ahead so ready is a flop
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interrupt_enable_latch <= 1'b0;
      int_mode <= `CFHR_IM_RESET;
      nmi_pend <= 1'b0;
      irq_arm <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else begin
      interrupt_enable_latch <= next_iel;
      nmi_pend <= next_nmi_pend;
      // Maskable request only counts while the latch is set
      irq_arm <= (next_nmi_pend || (int_req_i && next_iel)) &&
        (next_state == CFHR_ST_IDLE || next_state == CFHR_ST_HALTED);
      cmd_ready_o <= next_state == CFHR_ST_IDLE &&
        !(next_nmi_pend || (int_req_i && next_iel));
      if (take && cmd_i.op == CFHR_OP_IM) int_mode <= cmd_i.arg[1:0];
      if (reg_wr_i && reg_addr_i == `CFHR_OFS_CTRL) begin
        int_mode <= reg_wdata_i[`CFHR_CTRL_IM_LSB +: 2];
      end
    end
  end

  // Halt status pin
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_n_o <= 1'b1;
    end else if (state == CFHR_ST_IDLE && next_state == CFHR_ST_HALTED) begin
      halt_n_o <= 1'b0;
    end else if (state == CFHR_ST_HALTED && go) begin
      halt_n_o <= 1'b1;
    end
  end

  // Divider: one NOP fetch every NOP_CYCLES while halted
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nop_cnt <= '0;
      nop_tick <= 1'b0;
    end else begin
      nop_tick <= 1'b0;
      if (next_state != CFHR_ST_HALTED) begin
        nop_cnt <= '0;
      end else if (nop_cnt == ($bits(nop_cnt))'(NOP_CYCLES - 1)) begin
        nop_cnt <= '0;
        nop_tick <= 1'b1;
      end else begin
        nop_cnt <= nop_cnt + 1'b1;
      end
    end
  end

  // ==========================================
  // Program counter
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      program_counter <= `CFHR_PC_RESET;
    end else if (take && cmd_i.op == CFHR_OP_FETCH) begin
      program_counter <= addr_add(program_counter, 16'h0001);
    end else if (take && cmd_i.op == CFHR_OP_JUMP) begin
      program_counter <= cmd_i.arg;
    end else if (state == CFHR_ST_PUSH_LO && load_tgt) begin
      program_counter <= jump_tgt;
    end else if (state == CFHR_ST_POP_C && pop_to_pc) begin
      program_counter <= {mem_rdata_i, pop_low};
    end
  end

  // Stack pointer: no reset, software loads it first
  always_ff @(posedge mclk_i) begin
    if (state == CFHR_ST_PUSH_LO) begin
      stack_pointer <= addr_add(stack_pointer, 16'hFFFE);
    end else if (state == CFHR_ST_POP_C) begin
      stack_pointer <= addr_add(stack_pointer, 16'h0002);
    end else if (take && cmd_i.op == CFHR_OP_LDSP) begin
      stack_pointer <= cmd_i.arg;
    end else if (reg_wr_i && reg_addr_i == `CFHR_OFS_SP) begin
      stack_pointer <= reg_wdata_i[15:0];
    end
  end

  // Push and pop bookkeeping; only the PC is stacked by hardware
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      push_word <= 16'h0000;
      jump_tgt <= 16'h0000;
      load_tgt <= 1'b0;
      pop_to_pc <= 1'b0;
      pop_pair <= 2'h0;
      pop_low <= 8'h00;
    end else begin
      if (go) begin
        push_word <= program_counter;
        jump_tgt <= go_nmi ? `CFHR_NMI_VECTOR : int_vector_i;
        load_tgt <= 1'b1;
      end else if (take) begin
        push_word <= (cmd_i.op == CFHR_OP_PUSH) ? pair_rdata : program_counter;
        jump_tgt <= cmd_i.arg;
        load_tgt <= cmd_i.op == CFHR_OP_CALL;
        pop_to_pc <= cmd_i.op == CFHR_OP_RET;
        pop_pair <= cmd_i.pair;
      end
      if (state == CFHR_ST_POP_B) pop_low <= mem_rdata_i;
    end
  end

  // ==========================================
  // Memory bus requests, one byte per cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_o <= '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000, wdata: 8'h00};
    end else begin
      mem_o.rd_n <= 1'b1;
      mem_o.wr_n <= 1'b1;
      if ((state == CFHR_ST_IDLE || state == CFHR_ST_HALTED) &&
          next_state == CFHR_ST_PUSH_LO) begin
        // High byte first, at SP-1
        mem_o.wr_n <= 1'b0;
        mem_o.addr <= addr_add(stack_pointer, 16'hFFFF);
        mem_o.wdata <= go ? program_counter[15:8] :
          (cmd_i.op == CFHR_OP_PUSH ? pair_rdata[15:8] : program_counter[15:8]);
      end else if (state == CFHR_ST_PUSH_LO) begin
        mem_o.wr_n <= 1'b0;
        mem_o.addr <= addr_add(stack_pointer, 16'hFFFE);
        mem_o.wdata <= push_word[7:0];
      end else if (state == CFHR_ST_IDLE && next_state == CFHR_ST_POP_A) begin
        mem_o.rd_n <= 1'b0;
        mem_o.addr <= stack_pointer;
      end else if (state == CFHR_ST_POP_A) begin
        mem_o.rd_n <= 1'b0;
        mem_o.addr <= addr_add(stack_pointer, 16'h0001);
      end else if (refresh_tick) begin
        // Fetches and halted NOPs both present the PC
        mem_o.rd_n <= 1'b0;
        mem_o.addr <= program_counter;
      end
    end
  end

  // Refresh counter and page register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refresh <= `CFHR_REFRESH_RESET;
      page <= `CFHR_PAGE_RESET;
    end else if (reg_wr_i && reg_addr_i == `CFHR_OFS_REFRESH) begin
      page <= reg_wdata_i[15:8];
      refresh <= reg_wdata_i[7:0];
    end else if (refresh_tick) begin
      refresh <= {refresh[7], refresh[6:0] + 7'h01};
    end
  end

  // ==========================================
  // Pair storage, touched only by push, pop and exchange
  cfhr_pair_file u_pairs (
    .mclk_i(mclk_i),
    .rd_sel_i(cmd_i.pair),
    .rd_data_o(pair_rdata),
    .wr_en_i(state == CFHR_ST_POP_C && !pop_to_pc),
    .wr_sel_i(pop_pair),
    .wr_data_i({mem_rdata_i, pop_low}),
    .swap_alternate_set_i(take && cmd_i.op == CFHR_OP_EXX)
  );

  // ==========================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CFHR_OFS_PC: reg_rdata_o <= {16'h0000, program_counter};
        `CFHR_OFS_SP: reg_rdata_o <= {16'h0000, stack_pointer};
        `CFHR_OFS_REFRESH: reg_rdata_o <= {16'h0000, page, refresh};
        `CFHR_OFS_CTRL: reg_rdata_o <= {29'h0, int_mode, interrupt_enable_latch};
        `CFHR_OFS_STATUS: reg_rdata_o <= {30'h0, nmi_pend, state == CFHR_ST_HALTED};
        default: reg_rdata_o <= 32'h00000000; // Unmapped reads as zero
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_sp_push_two: assert property (state == CFHR_ST_PUSH_LO |=>
    stack_pointer == $past(stack_pointer) - 16'h0002) else $error("push did not lower SP by 2");
  a_push_high_slot: assert property ((state == CFHR_ST_IDLE && next_state == CFHR_ST_PUSH_LO)
    |=> !mem_o.wr_n && mem_o.addr == stack_pointer - 16'h0001 ##1
    !mem_o.wr_n && mem_o.addr == $past(stack_pointer, 2) - 16'h0002)
    else $error("push slots wrong");
  a_ret_load_pc: assert property ((state == CFHR_ST_POP_C && pop_to_pc) |=>
    program_counter == {$past(mem_rdata_i), $past(pop_low)}) else $error("return PC wrong");
  a_fetch_inc_pc: assert property ((take && cmd_i.op == CFHR_OP_FETCH && !go) |=>
    program_counter == $past(program_counter) + 16'h0001 && !mem_o.rd_n)
    else $error("fetch did not advance PC");
  a_jump_load_pc: assert property ((take && cmd_i.op == CFHR_OP_JUMP && !go) |=>
    program_counter == $past(cmd_i.arg)) else $error("jump target not loaded");
  a_halt_status_low: assert property (state == CFHR_ST_HALTED |-> !halt_n_o)
    else $error("halt status not low");
  a_halt_pc_hold: assert property (state == CFHR_ST_HALTED &&
    $past(state) == CFHR_ST_HALTED |-> $stable(program_counter)) else $error("PC moved in halt");
  // Only a register-port write may touch SP, page or mode while halted
  a_halt_regs_hold: assert property (state == CFHR_ST_HALTED &&
    $past(state) == CFHR_ST_HALTED && !$past(reg_wr_i) |->
    $stable(stack_pointer) && $stable(page) && $stable(int_mode)) else $error("regs moved in halt");
  a_halt_release_high: assert property ((state == CFHR_ST_HALTED && go) |=>
    halt_n_o && state == CFHR_ST_PUSH_LO) else $error("halt not released");
  a_dummy_two: assert property ((state == CFHR_ST_DUMMY && dcnt == 2'h0) |=>
    state == CFHR_ST_DUMMY ##1 state == CFHR_ST_IDLE) else $error("dummy length wrong");
  a_refresh_seven: assert property ((refresh_tick && !reg_wr_i) |=>
    refresh[6:0] == $past(refresh[6:0]) + 7'h01 && refresh[7] == $past(refresh[7]))
    else $error("refresh count wrong");

  c_halt_release: cover property (state == CFHR_ST_HALTED ##[1:40] state == CFHR_ST_PUSH_LO);
  c_call_push: cover property (take && cmd_i.op == CFHR_OP_CALL);
  c_ret_pop: cover property (state == CFHR_ST_POP_C && pop_to_pc);
  c_pair_pop: cover property (state == CFHR_ST_POP_C && !pop_to_pc);
endmodule
`default_nettype wire

// ### testbench/cfhr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Byte-wide system memory on the far side of the bus
module cfhr_mem_model
  import cfhr_pkg::*;
(
  input wire logic mclk_i,
  input wire cfhr_mem_s mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] store [65536]; // Whole 64K space
  // Seed every byte so that reads of untouched space are predictable
  initial begin
    for (int a = 0; a < 65536; a++) begin
      store[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
    end
    rdata_o = 8'h00;
  end
  // Writes land at the edge; read data stands one cycle only
  always @(posedge mclk_i) begin
    if (mem_i.wr_n === 1'b0) begin
      store[mem_i.addr] <= mem_i.wdata;
    end
    if (mem_i.rd_n === 1'b0) begin
      rdata_o <= store[mem_i.addr];
    end else begin
      rdata_o <= ~rdata_o; // Stale byte inverted so nobody can lean on it
    end
  end
endmodule
`default_nettype wire

// ### testbench/cfhr_flow_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfhr_params.svh"
// ==========================================
// Self-checking bench with a behavioural flow model
module cfhr_flow_ctrl_bench
  import cfhr_pkg::*;
;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid_i, nmi_req_i, int_req_i, reg_wr_i, reg_rd_i, cmd_ready_o, halt_n_o;
  cfhr_cmd_s cmd_i;
  cfhr_mem_s mem_o;
  logic [15:0] int_vector_i;
  logic [7:0] reg_addr_i, mem_rdata_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] pc_m, sp_m, vec; // Model program counter, stack pointer, vector
  logic [7:0] ref_m; // Model refresh counter
  logic [15:0] pair_m [4]; // Model register pairs
  logic [15:0] alt_m [3]; // Model alternate BC, DE, HL
  logic [7:0] bmem [65536]; // Mirror of memory contents
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int nop_seen = 0;
  // ==========================================
  // Design and far side
  cfhr_flow_ctrl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .nmi_req_i(nmi_req_i), .int_req_i(int_req_i),
    .int_vector_i(int_vector_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .halt_n_o(halt_n_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  cfhr_mem_model mem (.mclk_i(mclk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));
  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;
  // ==========================================
  // Reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // Fetches seen while halted must all come from the held counter
  always @(posedge mclk_i) begin
    if (halt_n_o === 1'b0 && mem_o.rd_n === 1'b0) begin
      nop_seen++;
      chk(32'(mem_o.addr), 32'(pc_m));
    end
  end
  // ==========================================
  // Bus tasks
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  // Two stack writes, high byte first one below the pointer
  task automatic stack_wr(input logic [15:0] v);
    chk(32'({mem_o.wr_n, mem_o.addr, mem_o.wdata}), 32'({1'b0, sp_m - 16'h1, v[15:8]}));
    step();
    chk(32'({mem_o.wr_n, mem_o.addr, mem_o.wdata}), 32'({1'b0, sp_m - 16'h2, v[7:0]}));
    bmem[sp_m - 16'h1] = v[15:8];
    bmem[sp_m - 16'h2] = v[7:0];
    sp_m = sp_m - 16'h2;
  endtask
  // One decoded command, held until taken, then its bus traffic checked
  task automatic send(input cfhr_op_e op, input logic [1:0] pr, input logic [15:0] arg);
    int k;
    logic [15:0] v;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op: op, pair: pr, arg: arg};
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (cmd_ready_o !== 1'b1 && k < 60);
    cmd_valid_i <= 1'b0;
    if (k >= 60) begin
      fails++;
    end
    #1;
    case (op)
      CFHR_OP_FETCH: begin
        chk(32'({mem_o.rd_n, mem_o.addr}), 32'({1'b0, pc_m}));
        pc_m = pc_m + 16'h1;
        ref_m = {ref_m[7], ref_m[6:0] + 7'h01};
      end
      CFHR_OP_JUMP: pc_m = arg;
      CFHR_OP_CALL, CFHR_OP_PUSH: begin
        v = (op == CFHR_OP_CALL) ? pc_m : pair_m[pr];
        stack_wr(v);
        if (op == CFHR_OP_CALL) begin
          pc_m = arg;
        end
      end
      CFHR_OP_RET, CFHR_OP_POP: begin
        chk(32'({mem_o.rd_n, mem_o.addr}), 32'({1'b0, sp_m}));
        step();
        chk(32'({mem_o.rd_n, mem_o.addr}), 32'({1'b0, sp_m + 16'h1}));
        v = {bmem[sp_m + 16'h1], bmem[sp_m]};
        sp_m = sp_m + 16'h2;
        if (op == CFHR_OP_RET) begin
          pc_m = v;
        end else begin
          pair_m[pr] = v;
        end
        // Pointer and target land two edges later; wait so reads see them
        repeat (2) step();
      end
      CFHR_OP_HALT: chk(32'(halt_n_o), 32'h0);
      CFHR_OP_EXX: begin
        for (int i = 0; i < 3; i++) begin
          {pair_m[i], alt_m[i]} = {alt_m[i], pair_m[i]};
        end
      end
      CFHR_OP_LDSP: sp_m = arg;
      default: ;
    endcase
  endtask
  // Interrupt entry: bounded wait for the push, then vector load
  task automatic int_entry(input logic [15:0] target);
    int k;
    k = 0;
    while (mem_o.wr_n !== 1'b0 && k < 30) begin
      step();
      k++;
    end
    int_req_i <= 1'b0;
    chk(32'(halt_n_o), 32'h1);
    stack_wr(pc_m);
    pc_m = target;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {cmd_valid_i, nmi_req_i, int_req_i, reg_wr_i, reg_rd_i} = '0;
    cmd_i = '{op: CFHR_OP_FETCH, pair: 2'h0, arg: 16'h0000};
    int_vector_i = 16'h0000;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    for (int a = 0; a < 65536; a++) begin
      bmem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
    end
    void'($urandom(34));
    repeat (12) @(posedge mclk_i);
    #1;
    chk(32'({halt_n_o, mem_o.rd_n, mem_o.wr_n, cmd_ready_o}), 32'hE);
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1;
    chk(32'(cmd_ready_o), 32'h0);
    step();
    chk(32'(cmd_ready_o), 32'h0);
    step();
    chk(32'(cmd_ready_o), 32'h1);
    pc_m = `CFHR_PC_RESET;
    ref_m = `CFHR_REFRESH_RESET;
    rd_chk(`CFHR_OFS_PC, 32'h0);
    rd_chk(`CFHR_OFS_REFRESH, 32'h0);
    rd_chk(`CFHR_OFS_CTRL, 32'h0);
    rd_chk(8'h14, 32'h0);
    // Straight-line fetch, jump, then a call from the stack example
    repeat (3) send(CFHR_OP_FETCH, 2'h0, 16'h0);
    send(CFHR_OP_JUMP, 2'h0, 16'h1230);
    repeat (3) send(CFHR_OP_FETCH, 2'h0, 16'h0);
    send(CFHR_OP_LDSP, 2'h0, 16'hFFF1);
    send(CFHR_OP_CALL, 2'h0, 16'h1500);
    rd_chk(`CFHR_OFS_SP, 32'h0000FFEF);
    rd_chk(`CFHR_OFS_PC, 32'(pc_m));
    rd_chk(`CFHR_OFS_REFRESH, 32'(ref_m));
    // Load pairs, push, pop in reverse, push again: order must be last-in first-out
    for (int i = 0; i < 4; i++) send(CFHR_OP_POP, 2'(i), 16'h0);
    for (int i = 0; i < 4; i++) send(CFHR_OP_PUSH, 2'(i), 16'h0);
    for (int i = 3; i >= 0; i--) send(CFHR_OP_POP, 2'(i), 16'h0);
    for (int i = 0; i < 4; i++) send(CFHR_OP_PUSH, 2'(i), 16'h0);
    for (int i = 0; i < 4; i++) send(CFHR_OP_POP, 2'(i), 16'h0);
    // The return address now sits in AF: stack it again for the return
    send(CFHR_OP_PUSH, 2'h3, 16'h0);
    send(CFHR_OP_RET, 2'h0, 16'h0);
    rd_chk(`CFHR_OFS_PC, 32'h00001233);
    // Exchange: pops land in the other bank, AF is not swapped
    send(CFHR_OP_EXX, 2'h0, 16'h0);
    for (int i = 0; i < 4; i++) send(CFHR_OP_POP, 2'(i), 16'h0);
    send(CFHR_OP_EXX, 2'h0, 16'h0);
    for (int i = 0; i < 4; i++) send(CFHR_OP_PUSH, 2'(i), 16'h0);
    // Enable latch and mode by command
    send(CFHR_OP_EI, 2'h0, 16'h0);
    send(CFHR_OP_IM, 2'h0, 16'h2);
    rd_chk(`CFHR_OFS_CTRL, 32'h5);
    send(CFHR_OP_DI, 2'h0, 16'h0);
    rd_chk(`CFHR_OFS_CTRL, 32'h4);
    // Halt, refused maskable request with the latch clear, then release
    send(CFHR_OP_HALT, 2'h0, 16'h0);
    nop_seen = 0;
    vec = 16'($urandom);
    int_vector_i <= vec;
    int_req_i <= 1'b1;
    repeat (16) step();
    chk(32'(halt_n_o), 32'h0);
    chk(32'(nop_seen > 2), 32'h1);
    rd_chk(`CFHR_OFS_STATUS, 32'h1);
    rd_chk(`CFHR_OFS_SP, 32'(sp_m));
    wr_reg(`CFHR_OFS_CTRL, 32'h1);
    int_entry(vec);
    ref_m = {ref_m[7], ref_m[6:0] + 7'(nop_seen)};
    rd_chk(`CFHR_OFS_CTRL, 32'h0);
    rd_chk(`CFHR_OFS_PC, 32'(pc_m));
    rd_chk(`CFHR_OFS_REFRESH, 32'(ref_m));
    // Non-maskable entry and return
    @(posedge mclk_i);
    nmi_req_i <= 1'b1;
    @(posedge mclk_i);
    nmi_req_i <= 1'b0;
    #1;
    int_entry(`CFHR_NMI_VECTOR);
    send(CFHR_OP_RET, 2'h0, 16'h0);
    rd_chk(`CFHR_OFS_PC, 32'(vec));
    // Reset in the middle of a halt, with latch and mode set beforehand
    send(CFHR_OP_EI, 2'h0, 16'h0);
    send(CFHR_OP_IM, 2'h0, 16'h1);
    send(CFHR_OP_HALT, 2'h0, 16'h0);
    repeat (5) step();
    arst_n_i = 1'b0;
    repeat (4) step();
    chk(32'(halt_n_o), 32'h1);
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    pc_m = `CFHR_PC_RESET;
    repeat (3) step();
    rd_chk(`CFHR_OFS_PC, 32'h0);
    rd_chk(`CFHR_OFS_SP, 32'(sp_m));
    rd_chk(`CFHR_OFS_CTRL, 32'h0);
    rd_chk(`CFHR_OFS_REFRESH, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
